// ### verilog/mesm_pkg.sv
// shared constants, register map and state types of the error signal monitor
package mesm_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 8;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  localparam int THR_W   = 16;
  localparam int TIMER_W = 17;
  localparam int FC_W    = 4;

  localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LOW_MAX  = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LOW_MIN  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_HIGH_MAX = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_HIGH_MIN = 8'h10;
  localparam logic [ADDR_W-1:0] REG_THRESH   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h18;

  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_MODE_BIT   = 1;
  localparam int CTRL_RSTEN_BIT  = 2;
  localparam int TH_ENDRV_LSB    = 0;
  localparam int TH_RST_LSB      = 4;
  localparam int STAT_FC_LSB     = 0;
  localparam int STAT_FAIL_BIT   = 4;
  localparam int STAT_RSTF_BIT   = 5;
  localparam int STAT_RUN_BIT    = 6;

  localparam logic [THR_W-1:0] LOW_MAX_RST  = 16'h0064;
  localparam logic [THR_W-1:0] LOW_MIN_RST  = 16'h000A;
  localparam logic [THR_W-1:0] HIGH_MAX_RST = 16'h0064;
  localparam logic [THR_W-1:0] HIGH_MIN_RST = 16'h000A;
  localparam logic [FC_W-1:0]  ENDRV_TH_RST = 4'h5;
  localparam logic [FC_W-1:0]  RST_TH_RST   = 4'hF;
  localparam logic [FC_W-1:0]  FC_DEFAULT   = 4'h0;
  localparam logic [FC_W-1:0]  FC_MAX       = 4'hF;

  typedef enum logic [2:0] {
    DEV_OFF    = 3'b000,
    DEV_RESET  = 3'b001,
    DEV_DIAG   = 3'b010,
    DEV_ACTIVE = 3'b011,
    DEV_SAFE   = 3'b100
  } mesm_dev_state_t;

  typedef enum logic [2:0] {
    S_IDLE      = 3'b000,
    S_LP_ARM    = 3'b001,
    S_LP_START  = 3'b010,
    S_LP_LOW    = 3'b011,
    S_PWM_ARM   = 3'b100,
    S_PWM_FIRST = 3'b101,
    S_PWM_SEC   = 3'b110
  } mesm_mon_state_t;

endpackage

// ### verilog/mesm_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module mesm_sync
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  output var  logic o_level
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ff1_reg <= 1'b1;
      ff2_reg <= 1'b1;
      ff3_reg <= 1'b1;
    end
    else
    begin
      ff1_reg <= i_pin;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // level moves only once the two settled stages agree
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_level <= 1'b1;
    else if (ff2_reg == ff3_reg)
      o_level <= ff3_reg;
  end
endmodule // mesm_sync
`default_nettype wire

// ### verilog/mesm_satcnt.sv
// saturating failure counter with reload
`timescale 1ns/100ps
`default_nettype none
module mesm_satcnt
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_init,
  input  wire logic                      i_inc,
  input  wire logic                      i_dec,
  output var  logic [mesm_pkg::FC_W-1:0] o_count
);
  import mesm_pkg::*;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_count <= FC_DEFAULT;
    else if (i_init)
      o_count <= FC_DEFAULT;
    else if (i_inc && o_count != FC_MAX)
      o_count <= o_count + 4'h1;
    else if (i_dec && !i_inc && o_count != 4'h0)
      o_count <= o_count - 4'h1;
  end

  count_sat_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_count == FC_MAX && i_inc && !i_init) |=> o_count == FC_MAX)
    else $error("failure counter wrapped past its top");
endmodule // mesm_satcnt
`default_nettype wire

// ### verilog/mesm_top.sv
// error signal monitor: pulse checks, failure counter, state requests
// How it works
// - one bit selects low-pulse or PWM mode
// - idle until software sets enable bit
// - low-pulse mode: each low checked against maximum
// - starting high: wait for first falling edge
// - starting low, no rise: error, count, retime
// - start-up timeout is low max plus high max
// - PWM mode uses four min/max thresholds
// - PWM starts on any edge; silence is error
// - pulse outside its limits: error, count, restart
// - low then high, both in range: decrement; code decrements any in-range phase pair, high then low included
// - new event right after error or success
// - active, no reset option: safe, output low
// - over reset threshold, option on: reset request
// - over reset threshold, option off: safe request
// - already safe: nothing further happens
// - listed events restart cycle, clear counter, flag
// - listed events reload counter to default
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
module mesm_top
(
  input  wire logic                              I_REF_CLK,
  input  wire logic                              I_RST_N,
  input  wire logic [mesm_pkg::ADDR_W-1:0]       I_ADDR,
  input  wire logic [mesm_pkg::DATA_W-1:0]       I_WDATA,
  input  wire logic                              I_WR,
  input  wire logic                              I_RD,
  output var  logic [mesm_pkg::DATA_W-1:0]       O_RDATA,
  input  wire logic                              I_MCU_ERR,
  input  wire mesm_pkg::mesm_dev_state_t         I_DEV_STATE,
  input  wire logic                              I_SELF_TEST_DONE,
  output var  logic                              O_REQ_SAFE,
  output var  logic                              O_REQ_RESET,
  output var  logic                              O_EN_INT_FORCE_LOW,
  output var  logic                              O_MONITOR_FAIL
);
  import mesm_pkg::*;

  localparam int SEQ_GAP = 1;

  logic                   en_reg;
  logic                   mode_reg;
  logic                   rsten_reg;
  logic [THR_W-1:0]       lmax_reg;
  logic [THR_W-1:0]       lmin_reg;
  logic [THR_W-1:0]       hmax_reg;
  logic [THR_W-1:0]       hmin_reg;
  logic [FC_W-1:0]        endrv_th_reg;
  logic [FC_W-1:0]        rst_th_reg;
  logic                   fail_reg;
  logic                   rstfail_reg;
  logic                   en_q_reg;
  logic                   mode_q_reg;
  mesm_dev_state_t        dev_q_reg;
  logic                   lvl;
  logic                   lvl_q_reg;
  logic                   edge_seen;
  logic [TICK_W-1:0]      tick_reg;
  logic                   tick;
  logic [TIMER_W-1:0]     timer_reg;
  logic [TIMER_W-1:0]     start_to;
  mesm_mon_state_t        state_reg;
  mesm_mon_state_t        state_next;
  logic                   restart;
  logic                   err;
  logic                   ok;
  logic                   phase_reg;
  logic                   phase_next;
  logic [TIMER_W-1:0]     min_cur;
  logic [TIMER_W-1:0]     max_cur;
  logic [FC_W-1:0]        fc;
  logic                   reset_entry;
  logic                   safe_to_diag;
  logic                   cycle_init;
  logic                   cnt_init;
  logic                   safe_cond;
  logic                   rst_cond;
  logic                   endrv_cond;
  logic                   safe_cond_q_reg;
  logic                   rst_cond_q_reg;
  logic                   flag_set;
  logic                   stat_wr;

  mesm_sync u_sync
  (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_pin   (I_MCU_ERR),
    .o_level (lvl)
  );

  // init wins over a same-cycle error; only cycle_init restarts the cycle, a safe_to_diag reload leaves it running
  mesm_satcnt u_fc
  (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .i_init  (cnt_init),
    .i_inc   (err),
    .i_dec   (ok),
    .o_count (fc)
  );

  // control and threshold registers
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      en_reg       <= 1'b0;
      mode_reg     <= 1'b0;
      rsten_reg    <= 1'b0;
      lmax_reg     <= LOW_MAX_RST;
      lmin_reg     <= LOW_MIN_RST;
      hmax_reg     <= HIGH_MAX_RST;
      hmin_reg     <= HIGH_MIN_RST;
      endrv_th_reg <= ENDRV_TH_RST;
      rst_th_reg   <= RST_TH_RST;
    end
    else if (I_WR)
    begin
      case (I_ADDR)
        REG_CTRL:
        begin
          en_reg    <= I_WDATA[CTRL_EN_BIT];
          mode_reg  <= I_WDATA[CTRL_MODE_BIT];
          rsten_reg <= I_WDATA[CTRL_RSTEN_BIT];
        end
        REG_LOW_MAX:  lmax_reg <= I_WDATA;
        REG_LOW_MIN:  lmin_reg <= I_WDATA;
        REG_HIGH_MAX: hmax_reg <= I_WDATA;
        REG_HIGH_MIN: hmin_reg <= I_WDATA;
        REG_THRESH:
        begin
          endrv_th_reg <= I_WDATA[TH_ENDRV_LSB +: FC_W];
          rst_th_reg   <= I_WDATA[TH_RST_LSB +: FC_W];
        end
        default: ;
      endcase
    end
  end

  // read data stands for the single cycle after the strobe
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_RDATA <= '0;
    else if (I_RD)
    begin
      case (I_ADDR)
        REG_CTRL:     O_RDATA <= DATA_W'({rsten_reg, mode_reg, en_reg});
        REG_LOW_MAX:  O_RDATA <= lmax_reg;
        REG_LOW_MIN:  O_RDATA <= lmin_reg;
        REG_HIGH_MAX: O_RDATA <= hmax_reg;
        REG_HIGH_MIN: O_RDATA <= hmin_reg;
        REG_THRESH:   O_RDATA <= DATA_W'({rst_th_reg, endrv_th_reg});
        REG_STATUS:   O_RDATA <= DATA_W'({state_reg != S_IDLE, rstfail_reg, fail_reg, fc});
        default:      O_RDATA <= '0;
      endcase
    end
    else
      O_RDATA <= '0;
  end

  // history for edge and transition detection
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      en_q_reg   <= 1'b0;
      mode_q_reg <= 1'b0;
      dev_q_reg  <= DEV_OFF;
      lvl_q_reg  <= 1'b1;
    end
    else
    begin
      en_q_reg   <= en_reg;
      mode_q_reg <= mode_reg;
      dev_q_reg  <= I_DEV_STATE;
      lvl_q_reg  <= lvl;
    end
  end

  assign edge_seen    = lvl != lvl_q_reg;
  assign reset_entry  = (I_DEV_STATE == DEV_RESET) && (dev_q_reg != DEV_RESET);
  assign safe_to_diag = (dev_q_reg == DEV_SAFE) && (I_DEV_STATE == DEV_DIAG);
  // power-on reset itself is covered by the asynchronous reset values
  assign cycle_init   = reset_entry || I_SELF_TEST_DONE || (mode_reg != mode_q_reg)
                        || (!en_reg && en_q_reg);
  assign cnt_init     = cycle_init || safe_to_diag || (en_reg && !en_q_reg);

  // microsecond tick keeps 16-bit thresholds useful at the fast core clock
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      tick_reg  <= '0;
      timer_reg <= '0;
    end
    else if (restart)
    begin
      tick_reg  <= '0;
      timer_reg <= '0;
    end
    else
    begin
      tick_reg <= tick ? '0 : tick_reg + 8'h01;
      if (tick && timer_reg != {TIMER_W{1'b1}})
        timer_reg <= timer_reg + 17'h00001;
    end
  end

  assign tick     = tick_reg == TICK_W'(TICK_CYCLES - 1);
  assign start_to = {1'b0, lmax_reg} + {1'b0, hmax_reg};
  assign min_cur  = {1'b0, phase_reg ? hmin_reg : lmin_reg};
  assign max_cur  = {1'b0, phase_reg ? hmax_reg : lmax_reg};

  // monitoring sequence
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    restart    = 1'b0;
    err        = 1'b0;
    ok         = 1'b0;
    case (state_reg)
      S_IDLE:
      begin
        restart = 1'b1;
        if (en_reg)
          state_next = mode_reg ? S_PWM_ARM : (lvl ? S_LP_ARM : S_LP_START);
      end
      S_LP_ARM:
      begin
        restart = 1'b1;
        if (edge_seen && !lvl)
          state_next = S_LP_LOW;
      end
      S_LP_START:
      begin
        if (edge_seen && lvl)
        begin
          restart    = 1'b1;
          state_next = S_LP_ARM;
        end
        else if (timer_reg > start_to)
        begin
          err     = 1'b1;
          restart = 1'b1;
        end
      end
      S_LP_LOW:
      begin
        if (edge_seen && lvl)
        begin
          ok         = 1'b1;
          restart    = 1'b1;
          state_next = S_LP_ARM;
        end
        else if (timer_reg > {1'b0, lmax_reg})
        begin
          err        = 1'b1;
          restart    = 1'b1;
          state_next = S_LP_START;
        end
      end
      S_PWM_ARM:
      begin
        if (edge_seen)
        begin
          restart    = 1'b1;
          phase_next = lvl;
          state_next = S_PWM_FIRST;
        end
        else if (timer_reg > start_to)
        begin
          err     = 1'b1;
          restart = 1'b1;
        end
      end
      S_PWM_FIRST, S_PWM_SEC:
      begin
        if (edge_seen)
        begin
          restart    = 1'b1;
          phase_next = lvl;
          if (timer_reg < min_cur)
          begin
            err        = 1'b1;
            state_next = S_PWM_FIRST;
          end
          else if (state_reg == S_PWM_SEC)
          begin
            ok         = 1'b1;
            state_next = S_PWM_FIRST;
          end
          else
            state_next = S_PWM_SEC;
        end
        else if (timer_reg > max_cur)
        begin
          err        = 1'b1;
          restart    = 1'b1;
          state_next = S_PWM_ARM;
        end
      end
      default:
      begin
        restart    = 1'b1;
        state_next = S_IDLE;
      end
    endcase
    if (cycle_init || !en_reg)
    begin
      state_next = S_IDLE;
      restart    = 1'b1;
      err        = 1'b0;
      ok         = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_reg <= S_IDLE;
      phase_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
    end
  end

  // threshold evaluation; in SAFE none of these hold, so nothing repeats
  assign endrv_cond = (I_DEV_STATE == DEV_ACTIVE) && !rsten_reg && (fc > endrv_th_reg);
  assign rst_cond   = ((I_DEV_STATE == DEV_DIAG) || (I_DEV_STATE == DEV_ACTIVE))
                      && (fc > rst_th_reg);
  assign safe_cond  = endrv_cond || (rst_cond && !rsten_reg);
  assign flag_set   = (safe_cond && !safe_cond_q_reg) || (rst_cond && rsten_reg && !rst_cond_q_reg);
  assign stat_wr    = I_WR && (I_ADDR == REG_STATUS);

  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      safe_cond_q_reg <= 1'b0;
      rst_cond_q_reg  <= 1'b0;
      O_REQ_SAFE      <= 1'b0;
      O_REQ_RESET     <= 1'b0;
    end
    else
    begin
      safe_cond_q_reg <= safe_cond;
      rst_cond_q_reg  <= rst_cond && rsten_reg;
      O_REQ_SAFE      <= safe_cond && !safe_cond_q_reg;
      O_REQ_RESET     <= rst_cond && rsten_reg && !rst_cond_q_reg;
    end
  end

  // status flags: write one to clear, a new failure wins over the clear
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      fail_reg    <= 1'b0;
      rstfail_reg <= 1'b0;
    end
    else if (flag_set)
    begin
      fail_reg    <= 1'b1;
      rstfail_reg <= 1'b1;
    end
    else
    begin
      if (cycle_init || (stat_wr && I_WDATA[STAT_FAIL_BIT]))
        fail_reg <= 1'b0;
      if (stat_wr && I_WDATA[STAT_RSTF_BIT])
        rstfail_reg <= 1'b0;
    end
  end

  // enable line is held low until the device leaves the safe condition
  always_ff @(posedge I_REF_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      O_EN_INT_FORCE_LOW <= 1'b0;
    else if (endrv_cond && !safe_cond_q_reg)
      O_EN_INT_FORCE_LOW <= 1'b1;
    else if (safe_to_diag || reset_entry)
      O_EN_INT_FORCE_LOW <= 1'b0;
  end

  assign O_MONITOR_FAIL = fail_reg;

  idle_when_off_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    !en_reg |=> state_reg == S_IDLE && !err)
    else $error("monitor ran while disabled");

  lp_arm_quiet_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    state_reg == S_LP_ARM |-> !err && !ok)
    else $error("counted before first falling edge");

  lp_low_max_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (err && state_reg == S_LP_LOW) |-> timer_reg > {1'b0, lmax_reg} && !lvl)
    else $error("low pulse flagged before its maximum");

  start_timeout_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (err && (state_reg == S_LP_START || state_reg == S_PWM_ARM))
    |-> timer_reg == start_to + 17'h00001 ##SEQ_GAP timer_reg == '0)
    else $error("start-up timeout not at low max plus high max");

  pwm_short_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (en_reg && !cycle_init && edge_seen && timer_reg < min_cur
     && (state_reg == S_PWM_FIRST || state_reg == S_PWM_SEC))
    |-> err ##1 state_reg == S_PWM_FIRST)
    else $error("short pwm pulse not flagged");

  count_up_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (err && !cnt_init && fc != FC_MAX) |=> fc == $past(fc) + 4'h1)
    else $error("error did not raise the counter");

  count_down_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    (ok && !cnt_init && fc != 4'h0) |=> fc == $past(fc) - 4'h1)
    else $error("correct signalling did not lower the counter");

  safe_pulse_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    $rose(safe_cond) |=> O_REQ_SAFE && fail_reg && rstfail_reg ##1 !O_REQ_SAFE)
    else $error("safe request not a single pulse with flags");

  init_clear_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
    cnt_init |=> fc == FC_DEFAULT)
    else $error("counter not reloaded");
endmodule // mesm_top
`default_nettype wire

// ### verif/mesm_mcu_model.sv
// host-side driver of the monitored error pin
`timescale 1ns/100ps
`default_nettype none
module mesm_mcu_model
(
  input  wire logic i_clk,
  output var  logic o_err
);
  initial o_err = 1'b1;

  // pin moves just after an edge and holds for cyc core cycles
  task automatic hold(input logic lvl, input int cyc);
    @(posedge i_clk);
    o_err <= lvl;
    repeat (cyc - 1) @(posedge i_clk);
  endtask

  // alternating phases of equal length, first level given
  task automatic burst(input logic first, input int n, input int cyc);
    for (int i = 0; i < n; i++)
    begin
      hold(first ^ i[0], cyc);
    end
  endtask
endmodule // mesm_mcu_model
`default_nettype wire

// ### verif/tb_mcu_error_signal_monitor.sv
// self-checking bench of the error signal monitor
`timescale 1ns/100ps
`default_nettype none
module tb_mcu_error_signal_monitor;
  import mesm_pkg::*;
  localparam int US = TICK_CYCLES;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              err_pin;
  mesm_dev_state_t   dev = DEV_DIAG;
  logic              st_done = 1'b0;
  logic              req_safe;
  logic              req_rst;
  logic              force_low;
  logic              mon_fail;
  logic [DATA_W-1:0] d;
  int                miscompares = 0;
  int                compares = 0;
  int                n_safe = 0;
  int                n_rst = 0;
  logic [ADDR_W-1:0] ra [8] = '{REG_CTRL, REG_LOW_MAX, REG_LOW_MIN, REG_HIGH_MAX,
                                REG_HIGH_MIN, REG_THRESH, REG_STATUS, 8'h1C};
  logic [DATA_W-1:0] rv [8] = '{16'h0000, LOW_MAX_RST, LOW_MIN_RST, HIGH_MAX_RST,
                                HIGH_MIN_RST, {8'h00, RST_TH_RST, ENDRV_TH_RST},
                                16'h0000, 16'h0000};

  always #2.5 clk = ~clk;

  mesm_top dut
  (
    .I_REF_CLK          (clk),
    .I_RST_N            (rst_n),
    .I_ADDR             (addr),
    .I_WDATA            (wdata),
    .I_WR               (wr),
    .I_RD               (rd),
    .O_RDATA            (rdata),
    .I_MCU_ERR          (err_pin),
    .I_DEV_STATE        (dev),
    .I_SELF_TEST_DONE   (st_done),
    .O_REQ_SAFE         (req_safe),
    .O_REQ_RESET        (req_rst),
    .O_EN_INT_FORCE_LOW (force_low),
    .O_MONITOR_FAIL     (mon_fail)
  );

  mesm_mcu_model mcu
  (
    .i_clk (clk),
    .o_err (err_pin)
  );

  // request outputs are one-cycle pulses, so each edge counts once
  always @(posedge clk)
  begin
    if (req_safe === 1'b1)
      n_safe++;
    if (req_rst === 1'b1)
      n_rst++;
  end

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] exp);
    rd_reg(REG_STATUS);
    chk(d & m, exp);
  endtask

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(ra[i]);
      chk(d, rv[i]);
    end
    // short thresholds: max 4 us, min 2 us keep every phase brief
    for (int i = 1; i < 5; i++)
    begin
      wr_reg(ra[i], i[0] ? 16'h0004 : 16'h0002);
      rd_reg(ra[i]);
      chk(d, i[0] ? 16'h0004 : 16'h0002);
    end
    wr_reg(REG_THRESH, 16'h00FF);
    // low-pulse mode starting high
    wr_reg(REG_CTRL, 16'h0001);
    mcu.hold(1'b1, 12 * US);
    chk_st(16'h000F, 16'h0000);
    mcu.hold(1'b0, 8 * US);
    mcu.hold(1'b1, 3 * US);
    chk_st(16'h000F, 16'h0001);
    mcu.hold(1'b0, 3 * US);
    mcu.hold(1'b1, US);
    chk_st(16'h000F, 16'h0000);
    mcu.hold(1'b0, 3 * US);
    mcu.hold(1'b1, US);
    chk_st(16'h000F, 16'h0000);
    // low-pulse mode starting low: timeout is low max plus high max
    wr_reg(REG_CTRL, 16'h0000);
    mcu.hold(1'b0, US);
    wr_reg(REG_CTRL, 16'h0001);
    mcu.hold(1'b0, 22 * US);
    chk_st(16'h000F, 16'h0002);
    wr_reg(REG_CTRL, 16'h0000);
    chk_st(16'h000F, 16'h0000);
    // pwm mode with no edge at all
    mcu.hold(1'b1, US);
    wr_reg(REG_CTRL, 16'h0003);
    mcu.hold(1'b1, 12 * US);
    chk_st(16'h000F, 16'h0001);
    wr_reg(REG_CTRL, 16'h0001);
    chk_st(16'h000F, 16'h0000);
    wr_reg(REG_CTRL, 16'h0000);
    // pwm short phases, then one good high and low pair
    wr_reg(REG_CTRL, 16'h0003);
    mcu.burst(1'b0, 4, US / 2);
    chk_st(16'h000F, 16'h0003);
    mcu.hold(1'b1, 3 * US);
    mcu.hold(1'b0, 3 * US);
    mcu.hold(1'b1, US);
    chk_st(16'h000F, 16'h0002);
    wr_reg(REG_CTRL, 16'h0000);
    // active state, counter passes the enable-drive threshold
    @(posedge clk);
    dev <= DEV_ACTIVE;
    wr_reg(REG_THRESH, 16'h0092);
    wr_reg(REG_CTRL, 16'h0003);
    mcu.burst(1'b0, 5, US / 2);
    chk(16'(n_safe), 16'h0001);
    chk({15'h0000, force_low}, 16'h0001);
    chk({15'h0000, mon_fail}, 16'h0001);
    chk_st(16'h0030, 16'h0030);
    @(posedge clk);
    dev <= DEV_SAFE;
    repeat (2) @(posedge clk);
    dev <= DEV_DIAG;
    repeat (2) @(posedge clk);
    chk({15'h0000, force_low}, 16'h0000);
    chk_st(16'h000F, 16'h0000);
    wr_reg(REG_CTRL, 16'h0000);
    // the flag clears one edge after enable drops, so let that edge pass
    repeat (2) @(posedge clk);
    chk({15'h0000, mon_fail}, 16'h0000);
    // diagnostic state, counter passes the reset threshold
    for (int r = 0; r < 2; r++)
    begin
      mcu.hold(1'b1, US);
      wr_reg(REG_THRESH, 16'h0039);
      wr_reg(REG_CTRL, 16'h0003 | 16'(r << 2));
      mcu.burst(1'b0, 5, US / 2);
      chk(16'(n_safe), 16'h0002);
      chk(16'(n_rst), 16'(r));
      chk_st(16'h0030, 16'h0030);
      if (r == 1)
      begin
        @(posedge clk);
        dev <= DEV_RESET;
        repeat (2) @(posedge clk);
        chk_st(16'h003F, 16'h0020);
      end
      wr_reg(REG_STATUS, 16'h0030);
      chk_st(16'h0030, 16'h0000);
      wr_reg(REG_CTRL, 16'h0000);
      @(posedge clk);
      dev <= DEV_DIAG;
    end
    // already safe with reset threshold not above enable-drive threshold
    mcu.hold(1'b1, US);
    @(posedge clk);
    dev <= DEV_SAFE;
    wr_reg(REG_THRESH, 16'h0035);
    wr_reg(REG_CTRL, 16'h0003);
    mcu.burst(1'b0, 20, US / 2);
    chk_st(16'h003F, 16'h000F);
    chk(16'(n_safe + n_rst), 16'h0003);
    @(posedge clk);
    st_done <= 1'b1;
    @(posedge clk);
    st_done <= 1'b0;
    chk_st(16'h000F, 16'h0000);
    wr_reg(REG_CTRL, 16'h0000);
    complete_run();
  end
endmodule // tb_mcu_error_signal_monitor
`default_nettype wire
